/* File: pkg/cdcs_pkg.sv */
package cdcs_pkg;
  // register map
  localparam logic [11:0] ADDR_UNLOCK   = 12'h700;
  localparam logic [11:0] ADDR_SER_CTRL = 12'h701;
  localparam logic [11:0] ADDR_CHN_CTRL = 12'h702;
  localparam logic [11:0] ADDR_STATUS   = 12'h780;
  localparam logic [11:0] ADDR_SER_CMD  = 12'h781;
  localparam logic [11:0] ADDR_SER_RSP  = 12'h782;
  localparam logic [11:0] ADDR_UP_BIT   = 12'h783;
  localparam logic [11:0] ADDR_UP_CMD   = 12'h784;

  localparam logic [7:0] UNLOCK_CODE    = 8'ha5;
  localparam logic [7:0] UNLOCK_RST     = 8'h00;
  localparam logic [7:0] SER_CTRL_RST   = 8'h04;
  localparam logic [3:0] CHN_CTRL_RST   = 4'hf;
  localparam logic [7:0] ZERO8          = 8'h00;

  // serial control fields
  localparam int SC_BAUD   = 4;
  localparam int SC_MIRROR = 3;
  localparam int SC_TX_EN  = 2;
  localparam int SC_SER_GT = 1;
  localparam int SC_CHN_GT = 0;
  localparam int SC_W      = 5;

  // chain control / status fields
  localparam int CH_LOW_TX = 3;
  localparam int CH_LOW_RX = 2;
  localparam int CH_UP_TX  = 1;
  localparam int CH_UP_RX  = 0;
  localparam int CH_W      = 4;
  localparam int ST_SER_SELF = 5;
  localparam int ST_CHN_SELF = 4;

  // serial command error fields
  localparam int CE_INIT  = 5;
  localparam int CE_TXDIS = 4;
  localparam int CE_SOF   = 3;
  localparam int CE_BYTE  = 2;
  localparam int CE_UNEXP = 1;
  localparam int CE_CRC   = 0;
  localparam int CE_W     = 6;

  // serial response / transmit error fields
  localparam int RE_TSOF  = 4;
  localparam int RE_WAIT  = 3;
  localparam int RE_RSOF  = 2;
  localparam int RE_BYTE  = 1;
  localparam int RE_CRC   = 0;
  localparam int RE_W     = 5;

  // upper port bit error fields
  localparam int UB_FRAME_ABNORMALITY_FLAG  = 4;
  localparam int UB_TAG   = 3;
  localparam int UB_DATA_AFTER_PREAMBLE_FAIL = 2;
  localparam int UB_PREAMBLE_DETECT_FAIL = 1;
  localparam int UB_WEAK  = 0;
  localparam int UB_W     = 5;

  // serial bit timing
  localparam int CLK_HZ   = 40_000_000;
  localparam int FAST_BPS = 1_000_000;
  localparam int SLOW_BPS = 250_000;
  localparam int FAST_CYC = CLK_HZ / FAST_BPS;
  localparam int SLOW_CYC = CLK_HZ / SLOW_BPS;
  localparam int BAUD_W   = 8;
endpackage

/* File: verilog/cdcs_top.sv */
// Notes on behaviour
// - overrides apply only while key unlocked
// - other key value cancels all overrides
// - serial 1 Mb/s, or 250 kb/s
// - stacked device serial transmitter off unless enabled
// - serial gate bit qualifies transmit and mirror
// - chain gate bit qualifies port enables
// - four port enables, one means on
// - after byte error ignore until clear
// - ignored frame: no command errors, no counts
// - flag clear arriving mid command frame
// - flag stack command at stacked device unless shared bus
// - crc failure flags and discards frame
// - flag clear arriving during transmission
// - upper abnormality flags and tags forward
// - flag incoming frame already tagged
// - flag sync found but data lost
// - flag preamble or sync not found
// - flag weak data bit decision
// - upper crc flag hides other errors
`timescale 1ns/1ps
`default_nettype none
module cdcs_top (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic [11:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  input  wire logic        stack_dev_in,
  input  wire logic        shared_bus_mode_in,
  input  wire logic        dir_sel_in,
  input  wire logic [3:0]  chain_norm_en_in,
  input  wire logic        ser_cmd_start_in,
  input  wire logic        ser_cmd_end_in,
  input  wire logic        ser_clear_in,
  input  wire logic        ser_init_err_in,
  input  wire logic        ser_byte_err_in,
  input  wire logic        ser_crc_err_in,
  input  wire logic        ser_read_cmd_in,
  input  wire logic        ser_stack_cmd_in,
  input  wire logic        ser_tx_busy_in,
  input  wire logic        ser_resp_pending_in,
  input  wire logic        ser_resp_rx_in,
  input  wire logic        ser_resp_byte_err_in,
  input  wire logic        ser_resp_crc_err_in,
  input  wire logic        up_frame_end_in,
  input  wire logic        up_tag_in,
  input  wire logic        up_sync_data_bad_in,
  input  wire logic        up_no_sync_in,
  input  wire logic        up_weak_bit_in,
  input  wire logic        up_abnormal_in,
  input  wire logic        up_crc_err_in,
  input  wire logic        up_cmd_frame_in,
  output logic             serial_tx_on_out,
  output logic             response_mirror_on_out,
  output logic             baud_slow_out,
  output logic             bit_tick_out,
  output logic      [3:0]  chain_port_state_out,
  output logic             ser_ignore_out,
  output logic             ser_discard_out,
  output logic             forwarded_error_tag_out
);
  logic [7:0]             key_r;
  logic [cdcs_pkg::SC_W-1:0] sctl_r;
  logic [cdcs_pkg::CH_W-1:0] cctl_r;
  logic [cdcs_pkg::CE_W-1:0] cerr_r;
  logic [cdcs_pkg::RE_W-1:0] rerr_r;
  logic [cdcs_pkg::UB_W-1:0] uerr_r;
  logic [1:0]             ucmd_r;
  logic [cdcs_pkg::UB_W-1:0] upend_r;
  logic                   ign_r;
  logic                   infrm_r;
  logic [7:0]             rdata_r;
  logic [cdcs_pkg::BAUD_W-1:0] bcnt_r;
  logic                   tick_r;
  logic                   unlocked;
  logic                   ser_ovr;
  logic                   chn_ovr;
  logic                   tx_eff;
  logic [3:0]             ports_eff;
  logic [cdcs_pkg::CE_W-1:0] cset;
  logic [cdcs_pkg::RE_W-1:0] rset;
  logic [cdcs_pkg::UB_W-1:0] ufrm;
  logic                   ucommit;
  logic [7:0]             rd_mux;
  logic                   rd_hit;
  logic [cdcs_pkg::BAUD_W-1:0] bit_last;
  logic [cdcs_pkg::BAUD_W-1:0] tper_r;
  logic                   tfast_r;

  // overrides live only while the key holds the code
  assign unlocked = (key_r == cdcs_pkg::UNLOCK_CODE);
  assign ser_ovr  = unlocked & sctl_r[cdcs_pkg::SC_SER_GT];
  assign chn_ovr  = unlocked & sctl_r[cdcs_pkg::SC_CHN_GT];
  assign tx_eff   = ser_ovr ? sctl_r[cdcs_pkg::SC_TX_EN]
                            : ~stack_dev_in;
  assign ports_eff = chn_ovr ? cctl_r : chain_norm_en_in;

  // register writes
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      key_r  <= cdcs_pkg::UNLOCK_RST;
      sctl_r <= cdcs_pkg::SER_CTRL_RST[cdcs_pkg::SC_W-1:0];
      cctl_r <= cdcs_pkg::CHN_CTRL_RST;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        cdcs_pkg::ADDR_UNLOCK:   key_r  <= reg_wdata_in;
        cdcs_pkg::ADDR_SER_CTRL: sctl_r <= reg_wdata_in[cdcs_pkg::SC_W-1:0];
        cdcs_pkg::ADDR_CHN_CTRL: cctl_r <= reg_wdata_in[cdcs_pkg::CH_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // applied port configuration, registered toward the port logic
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      serial_tx_on_out       <= 1'b0;
      response_mirror_on_out <= 1'b0;
      baud_slow_out          <= 1'b0;
      chain_port_state_out   <= 4'h0;
    end else begin
      serial_tx_on_out       <= tx_eff;
      // mirroring is meaningless without the transmitter
      response_mirror_on_out <= ser_ovr & tx_eff &
                                sctl_r[cdcs_pkg::SC_MIRROR];
      baud_slow_out          <= unlocked & sctl_r[cdcs_pkg::SC_BAUD];
      chain_port_state_out   <= ports_eff;
    end
  end

  // serial bit tick, count runs on through a rate change without restarting
  assign bit_last = baud_slow_out ?
    cdcs_pkg::BAUD_W'(cdcs_pkg::SLOW_CYC - 1) :
    cdcs_pkg::BAUD_W'(cdcs_pkg::FAST_CYC - 1);
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bcnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (bcnt_r >= bit_last);
      bcnt_r <= (bcnt_r >= bit_last) ? '0 : bcnt_r + 1'b1;
    end
  end
  assign bit_tick_out = tick_r;

  // serial frame tracking and the ignore window
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ign_r   <= 1'b0;
      infrm_r <= 1'b0;
    end else begin
      if (ser_clear_in)
        ign_r <= 1'b0;
      else if (ser_byte_err_in | ser_init_err_in)
        ign_r <= 1'b1;
      if (ser_clear_in | ser_cmd_end_in)
        infrm_r <= 1'b0;
      else if (ser_cmd_start_in)
        infrm_r <= 1'b1;
    end
  end
  assign ser_ignore_out = ign_r;

  // error events; command errors and response byte and crc errors are masked inside an ignored frame
  always_comb begin
    cset = '0;
    rset = '0;
    if (!ign_r) begin
      cset[cdcs_pkg::CE_INIT]  = ser_init_err_in;
      cset[cdcs_pkg::CE_BYTE]  = ser_byte_err_in;
      cset[cdcs_pkg::CE_TXDIS] = ser_read_cmd_in & ~tx_eff;
      cset[cdcs_pkg::CE_UNEXP] = ser_stack_cmd_in & stack_dev_in &
                                 ~shared_bus_mode_in;
      cset[cdcs_pkg::CE_CRC]   = ser_crc_err_in;
      rset[cdcs_pkg::RE_BYTE]  = ser_resp_byte_err_in;
      rset[cdcs_pkg::RE_CRC]   = ser_resp_crc_err_in;
    end
    cset[cdcs_pkg::CE_SOF]  = ser_clear_in & infrm_r & ~ign_r;
    rset[cdcs_pkg::RE_TSOF] = ser_clear_in & ser_tx_busy_in;
    rset[cdcs_pkg::RE_WAIT] = ser_resp_pending_in &
                              (ser_clear_in | ser_cmd_start_in);
    rset[cdcs_pkg::RE_RSOF] = ser_clear_in & ser_resp_rx_in;
  end

  // discard pulse toward the frame counters
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      ser_discard_out <= 1'b0;
    else
      ser_discard_out <= ~ign_r & ser_crc_err_in;
  end

  // upper port: errors wait for the frame end, crc drops them
  always_comb begin
    ufrm = upend_r;
    ufrm[cdcs_pkg::UB_TAG]   = upend_r[cdcs_pkg::UB_TAG] | up_tag_in;
    ufrm[cdcs_pkg::UB_DATA_AFTER_PREAMBLE_FAIL] = upend_r[cdcs_pkg::UB_DATA_AFTER_PREAMBLE_FAIL] |
                               up_sync_data_bad_in;
    ufrm[cdcs_pkg::UB_PREAMBLE_DETECT_FAIL] = upend_r[cdcs_pkg::UB_PREAMBLE_DETECT_FAIL] |
                               up_no_sync_in;
    ufrm[cdcs_pkg::UB_WEAK]  = upend_r[cdcs_pkg::UB_WEAK] |
                               up_weak_bit_in;
    ufrm[cdcs_pkg::UB_FRAME_ABNORMALITY_FLAG]  = upend_r[cdcs_pkg::UB_FRAME_ABNORMALITY_FLAG] | up_tag_in |
                               up_abnormal_in | up_sync_data_bad_in |
                               up_no_sync_in | up_weak_bit_in;
  end
  assign ucommit = up_frame_end_in & ~up_crc_err_in;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upend_r                 <= '0;
      forwarded_error_tag_out <= 1'b0;
    end else begin
      upend_r                 <= up_frame_end_in ? '0 : ufrm;
      forwarded_error_tag_out <= ucommit & ufrm[cdcs_pkg::UB_FRAME_ABNORMALITY_FLAG];
    end
  end

  // read data and read-to-clear of the sticky flags
  assign rd_hit = reg_rd_in;
  always_comb begin
    case (reg_addr_in)
      cdcs_pkg::ADDR_UNLOCK:   rd_mux = key_r;
      cdcs_pkg::ADDR_SER_CTRL: rd_mux = {3'h0, sctl_r};
      cdcs_pkg::ADDR_CHN_CTRL: rd_mux = {4'h0, cctl_r};
      cdcs_pkg::ADDR_STATUS:   rd_mux = {2'h0, ~ser_ovr, ~chn_ovr,
                                         chain_port_state_out};
      cdcs_pkg::ADDR_SER_CMD:  rd_mux = {2'h0, cerr_r};
      cdcs_pkg::ADDR_SER_RSP:  rd_mux = {3'h0, rerr_r};
      cdcs_pkg::ADDR_UP_BIT:   rd_mux = {3'h0, uerr_r};
      cdcs_pkg::ADDR_UP_CMD:   rd_mux = {6'h00, ucmd_r};
      default:                 rd_mux = cdcs_pkg::ZERO8;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      rdata_r <= cdcs_pkg::ZERO8;
    else
      rdata_r <= rd_hit ? rd_mux : cdcs_pkg::ZERO8;
  end
  assign reg_rdata_out = rdata_r;

  // sticky flags: a new event beats the clearing read
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cerr_r <= '0;
      rerr_r <= '0;
      uerr_r <= '0;
      ucmd_r <= '0;
    end else begin
      cerr_r <= ((rd_hit && reg_addr_in == cdcs_pkg::ADDR_SER_CMD) ?
                 '0 : cerr_r) | cset;
      rerr_r <= ((rd_hit && reg_addr_in == cdcs_pkg::ADDR_SER_RSP) ?
                 '0 : rerr_r) | rset;
      uerr_r <= ((rd_hit && reg_addr_in == cdcs_pkg::ADDR_UP_BIT) ?
                 '0 : uerr_r) | (ucommit ? ufrm : '0);
      ucmd_r <= ((rd_hit && reg_addr_in == cdcs_pkg::ADDR_UP_CMD) ?
                 2'b00 : ucmd_r) |
                {up_cmd_frame_in & dir_sel_in,
                 up_frame_end_in & up_crc_err_in};
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  property p_lock_drop;
    reg_wr_in && reg_addr_in == cdcs_pkg::ADDR_UNLOCK &&
    reg_wdata_in != cdcs_pkg::UNLOCK_CODE
      ##1 !(reg_wr_in && reg_addr_in == cdcs_pkg::ADDR_UNLOCK)
      |=> !response_mirror_on_out && !baud_slow_out;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("relock kept");

  property p_ser_gate;
    !ser_ovr |=> serial_tx_on_out == $past(~stack_dev_in);
  endproperty
  a_ser_gate: assert property (p_ser_gate) else $error("tx not normal");

  property p_chain_gate;
    !chn_ovr |=> chain_port_state_out == $past(chain_norm_en_in);
  endproperty
  a_chain_gate: assert property (p_chain_gate) else $error("gate leak");

  property p_chain_ovr;
    chn_ovr |=> chain_port_state_out == $past(cctl_r);
  endproperty
  a_chain_ovr: assert property (p_chain_ovr) else $error("ovr missing");

  property p_mirror_needs_tx;
    response_mirror_on_out |-> serial_tx_on_out;
  endproperty
  a_mirror_needs_tx: assert property (p_mirror_needs_tx)
    else $error("mirror without tx");

  // period watch for the bit tick; a period with a rate change is skipped
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tper_r  <= '0;
      tfast_r <= 1'b0;
    end else begin
      tper_r  <= tick_r ? '0 : tper_r + 1'b1;
      tfast_r <= ~baud_slow_out & (tick_r | tfast_r);
    end
  end

  property p_tick_fast;
    tick_r && tfast_r |->
      tper_r == cdcs_pkg::BAUD_W'(cdcs_pkg::FAST_CYC - 1);
  endproperty
  a_tick_fast: assert property (p_tick_fast) else $error("fast period");

  property p_ignore_hold;
    ign_r && !ser_clear_in |=> ign_r;
  endproperty
  a_ignore_hold: assert property (p_ignore_hold) else $error("dropped");

  property p_ignore_quiet;
    ign_r && ser_crc_err_in |=> !ser_discard_out;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet)
    else $error("ignored frame counted");

  property p_txdis;
    !ign_r && ser_read_cmd_in && !serial_tx_on_out && $stable(tx_eff)
      |=> cerr_r[cdcs_pkg::CE_TXDIS];
  endproperty
  a_txdis: assert property (p_txdis) else $error("tx off read missed");

  property p_unexp;
    !ign_r && ser_stack_cmd_in && stack_dev_in && !shared_bus_mode_in
      |=> cerr_r[cdcs_pkg::CE_UNEXP];
  endproperty
  a_unexp: assert property (p_unexp) else $error("stack cmd missed");

  property p_tsof;
    ser_clear_in && ser_tx_busy_in |=> rerr_r[cdcs_pkg::RE_TSOF];
  endproperty
  a_tsof: assert property (p_tsof) else $error("clear in tx missed");

  property p_crc_hides;
    up_frame_end_in && up_crc_err_in && uerr_r == '0 &&
    !(reg_rd_in && reg_addr_in == cdcs_pkg::ADDR_UP_BIT)
      |=> uerr_r == '0 && !forwarded_error_tag_out;
  endproperty
  a_crc_hides: assert property (p_crc_hides) else $error("crc leak");

  c_unlock: cover property (unlocked ##1 serial_tx_on_out);
  c_ignore: cover property (ser_byte_err_in ##[1:20] ser_clear_in);
  c_tag: cover property (forwarded_error_tag_out);
  c_slow: cover property (baud_slow_out && tick_r);
endmodule
`default_nettype wire

/* File: tb/cdcs_chain_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cdcs_chain_model (
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  input  wire logic       go_in,
  input  wire logic [4:0] err_mask_in,
  input  wire logic       crc_err_in,
  output logic      [4:0] err_pulse_out,
  output logic            frame_end_out,
  output logic            crc_pulse_out
);
  // upper neighbour: one frame per go, faults mid-frame, end two later
  logic [1:0] phase_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_r       <= 2'h0;
      err_pulse_out <= 5'h00;
      frame_end_out <= 1'b0;
      crc_pulse_out <= 1'b0;
    end else begin
      phase_r       <= {phase_r[0], go_in};
      err_pulse_out <= go_in ? err_mask_in : 5'h00;
      frame_end_out <= phase_r[1];
      // crc only at frame end, where the checker commits it
      crc_pulse_out <= phase_r[1] & crc_err_in;
    end
  end
endmodule
`default_nettype wire

/* File: tb/cdcs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module cdcs_top_tb;
  localparam logic [10:0] START = 11'h001;
  localparam logic [10:0] FEND  = 11'h002;
  localparam logic [10:0] CLR   = 11'h004;
  localparam logic [10:0] INIT  = 11'h008;
  localparam logic [10:0] BYTE  = 11'h010;
  localparam logic [10:0] CRC   = 11'h020;
  localparam logic [10:0] RDC   = 11'h040;
  localparam logic [10:0] STK   = 11'h080;
  localparam logic [10:0] UPC   = 11'h100;
  localparam logic [10:0] RBYTE = 11'h200;
  localparam logic [10:0] RCRC  = 11'h400;
  logic        ref_clk_in, rst_b_in, reg_wr_in, reg_rd_in, go, crc;
  logic [11:0] reg_addr_in;
  logic [7:0]  reg_wdata_in, reg_rdata_out;
  logic        stack_dev_in, shared_bus_mode_in, dir_sel_in;
  logic        ser_tx_busy_in, ser_resp_pending_in, ser_resp_rx_in;
  logic [3:0]  chain_norm_en_in, chain_port_state_out;
  logic [10:0] ev_r;
  logic [4:0]  mask, up_err;
  logic        up_end, up_crc, serial_tx_on_out, response_mirror_on_out;
  logic        baud_slow_out, bit_tick_out, ser_ignore_out;
  logic        ser_discard_out, forwarded_error_tag_out;
  int          failures, n_checks;

  cdcs_top u_dut (
    .ref_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out, .stack_dev_in, .shared_bus_mode_in,
    .dir_sel_in, .chain_norm_en_in, .ser_cmd_start_in(ev_r[0]),
    .ser_cmd_end_in(ev_r[1]), .ser_clear_in(ev_r[2]),
    .ser_init_err_in(ev_r[3]), .ser_byte_err_in(ev_r[4]),
    .ser_crc_err_in(ev_r[5]), .ser_read_cmd_in(ev_r[6]),
    .ser_stack_cmd_in(ev_r[7]), .ser_tx_busy_in, .ser_resp_pending_in,
    .ser_resp_rx_in, .ser_resp_byte_err_in(ev_r[9]),
    .ser_resp_crc_err_in(ev_r[10]), .up_frame_end_in(up_end),
    .up_tag_in(up_err[3]), .up_sync_data_bad_in(up_err[2]),
    .up_no_sync_in(up_err[1]), .up_weak_bit_in(up_err[0]),
    .up_abnormal_in(up_err[4]), .up_crc_err_in(up_crc),
    .up_cmd_frame_in(ev_r[8]), .serial_tx_on_out, .response_mirror_on_out,
    .baud_slow_out, .bit_tick_out, .chain_port_state_out, .ser_ignore_out,
    .ser_discard_out, .forwarded_error_tag_out);

  cdcs_chain_model u_chain (
    .clk_in(ref_clk_in), .rst_b_in(rst_b_in), .go_in(go),
    .err_mask_in(mask), .crc_err_in(crc), .err_pulse_out(up_err),
    .frame_end_out(up_end), .crc_pulse_out(up_crc));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // ends two edges after the write so applied outputs have landed
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
    repeat (2) @(negedge ref_clk_in);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    @(negedge ref_clk_in);
    chk8(reg_rdata_out, e);
  endtask

  task automatic ev(input logic [10:0] m, input logic [11:0] a,
                    input logic [7:0] e, input logic disc);
    @(posedge ref_clk_in);
    ev_r <= m;
    @(posedge ref_clk_in);
    ev_r <= 11'h000;
    @(negedge ref_clk_in);
    chk1(ser_discard_out, disc);
    rd(a, e);
  endtask

  task automatic tick(input logic [7:0] e);
    logic [7:0] n;
    n = 8'h00;
    repeat (400) begin
      @(negedge ref_clk_in);
      if (bit_tick_out === 1'b1) break;
    end
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (bit_tick_out !== 1'b1 && n < 8'd200);
    chk8(n, e);
  endtask

  task automatic up(input logic [4:0] m, input logic c, input logic t,
                    input logic [7:0] e3, input logic [7:0] e4);
    @(posedge ref_clk_in);
    go <= 1'b1;
    mask <= m;
    crc <= c;
    @(posedge ref_clk_in);
    go <= 1'b0;
    repeat (6) begin
      @(negedge ref_clk_in);
      if (up_end === 1'b1) break;
    end
    @(negedge ref_clk_in);
    chk1(forwarded_error_tag_out, t);
    @(negedge ref_clk_in);
    chk1(forwarded_error_tag_out, 1'b0);
    rd(12'h783, e3);
    rd(12'h784, e4);
  endtask

  task automatic t_reset();
    repeat (2) @(negedge ref_clk_in);
    chk1(serial_tx_on_out, 1'b0);
    rd(12'h700, 8'h00);
    rd(12'h701, 8'h04);
    rd(12'h702, 8'h0f);
    @(negedge ref_clk_in);
    chk8(reg_rdata_out, 8'h00);
    rd(12'h780, 8'h3a);
    for (int i = 1; i <= 4; i++) rd(12'(12'h780 + i), 8'h00);
    wr(12'h781, 8'hff);
    rd(12'h781, 8'h00);
    rd(12'h7ff, 8'h00);
  endtask

  task automatic t_ctrl();
    wr(12'h701, 8'h06);
    chk1(serial_tx_on_out, 1'b0);
    wr(12'h700, 8'ha5);
    chk1(serial_tx_on_out, 1'b1);
    ev(RDC, 12'h781, 8'h00, 1'b0);
    wr(12'h701, 8'h04);
    chk1(serial_tx_on_out, 1'b0);
    wr(12'h701, 8'h0e);
    chk1(response_mirror_on_out, 1'b1);
    wr(12'h701, 8'h0a);
    chk1(response_mirror_on_out, 1'b0);
    wr(12'h702, 8'hf5);
    rd(12'h702, 8'h05);
    chk8({4'h0, chain_port_state_out}, 8'h0a);
    wr(12'h701, 8'hff);
    rd(12'h701, 8'h1f);
    chk8({4'h0, chain_port_state_out}, 8'h05);
    rd(12'h780, 8'h05);
    chk1(baud_slow_out, 1'b1);
    tick(8'(cdcs_pkg::SLOW_CYC));
    wr(12'h700, 8'h3c);
    chk1(serial_tx_on_out, 1'b0);
    chk1(response_mirror_on_out, 1'b0);
    rd(12'h780, 8'h3a);
    tick(8'(cdcs_pkg::FAST_CYC));
    @(posedge ref_clk_in);
    stack_dev_in <= 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk1(serial_tx_on_out, 1'b1);
    @(posedge ref_clk_in);
    stack_dev_in <= 1'b1;
  endtask

  task automatic t_serial();
    @(posedge ref_clk_in);
    ser_tx_busy_in <= 1'b1;
    ser_resp_pending_in <= 1'b1;
    ev(CLR, 12'h782, 8'h18, 1'b0);
    @(posedge ref_clk_in);
    ser_tx_busy_in <= 1'b0;
    ev(START, 12'h782, 8'h08, 1'b0);
    @(posedge ref_clk_in);
    ser_resp_pending_in <= 1'b0;
    ev(FEND, 12'h781, 8'h00, 1'b0);
    ev(START, 12'h781, 8'h00, 1'b0);
    ev(CLR, 12'h781, 8'h08, 1'b0);
    ev(RDC, 12'h781, 8'h10, 1'b0);
    ev(STK, 12'h781, 8'h02, 1'b0);
    @(posedge ref_clk_in);
    shared_bus_mode_in <= 1'b1;
    ev(STK, 12'h781, 8'h00, 1'b0);
    ev(CRC, 12'h781, 8'h01, 1'b1);
    @(posedge ref_clk_in);
    ser_resp_rx_in <= 1'b1;
    // only command crc failures pulse the discard output
    ev(RCRC, 12'h782, 8'h01, 1'b0);
    ev(RBYTE, 12'h782, 8'h02, 1'b0);
    ev(CLR, 12'h782, 8'h04, 1'b0);
    @(posedge ref_clk_in);
    ser_resp_rx_in <= 1'b0;
  endtask

  task automatic t_ignore();
    ev(INIT, 12'h781, 8'h20, 1'b0);
    chk1(ser_ignore_out, 1'b1);
    ev(CLR, 12'h781, 8'h00, 1'b0);
    ev(BYTE, 12'h781, 8'h04, 1'b0);
    ev(CRC | RDC, 12'h781, 8'h00, 1'b0);
    chk1(ser_ignore_out, 1'b1);
    ev(CLR, 12'h781, 8'h00, 1'b0);
    chk1(ser_ignore_out, 1'b0);
  endtask

  task automatic t_upper();
    for (int i = 0; i < 5; i++)
      up(5'(1<<i), 1'b0, 1'b1, 8'h10 | 8'(1<<i), 8'h00);
    up(5'h01, 1'b1, 1'b0, 8'h00, 8'h01);
    @(posedge ref_clk_in);
    dir_sel_in <= 1'b1;
    ev(UPC, 12'h784, 8'h02, 1'b0);
    @(posedge ref_clk_in);
    dir_sel_in <= 1'b0;
    ev(UPC, 12'h784, 8'h00, 1'b0);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // generous: the whole sequence needs well under a thousand cycles
  initial begin
    #(25 * 10000);
    failures++;
    complete_run();
  end

  initial begin
    failures = 0;
    n_checks = 0;
    rst_b_in = 1'b0;
    {reg_wr_in, reg_rd_in, go, crc} = 4'h0;
    reg_addr_in = 12'h000;
    reg_wdata_in = 8'h00;
    {stack_dev_in, shared_bus_mode_in, dir_sel_in} = 3'h4;
    {ser_tx_busy_in, ser_resp_pending_in, ser_resp_rx_in} = 3'h0;
    chain_norm_en_in = 4'ha;
    ev_r = 11'h000;
    mask = 5'h00;
    repeat (6) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    t_reset();
    t_ctrl();
    t_serial();
    t_ignore();
    t_upper();
    complete_run();
  end
endmodule
`default_nettype wire
